// >>> src/mb_params.svh
// Purpose: Shared constants for the serial command link
// Assumes: Byte-wide link, one byte per clock when valid
// Notes:   Included by the package and by both ends
`ifndef MB_PARAMS_SVH
`define MB_PARAMS_SVH

`define MB_FN_RD_COIL   8'h01
`define MB_FN_RD_REG    8'h03
`define MB_FN_WR_COIL   8'h05
`define MB_FN_WR_REG    8'h06
`define MB_FN_EXC_FLAG  8'h80

`define MB_EXC_FUNC     8'h01
`define MB_EXC_ADDR     8'h02
`define MB_EXC_DATA     8'h03
`define MB_EXC_REJECT   8'h22

`define MB_COIL_ON      16'hff00
`define MB_COIL_OFF     16'h0000
`define MB_COIL_MAX     6'h20
`define MB_REG_MAX      6'h04
`define MB_COIL_LIMIT   16'h0040
`define MB_REG_LIMIT    16'h0040

`define MB_ADDR_BCAST   8'h00
`define MB_ADDR_MIN     8'h01
`define MB_ADDR_MAX     8'h20

`define MB_REQ_LEN      4'h8
`define MB_CNT_SAT      4'hf
`define MB_CRC_INIT     16'hffff
`define MB_CRC_POLY     16'ha001

`define MB_RSP_MAX      4'hd
`define MB_RSP_TIMEOUT  10'h3e8

`endif

// >>> src/mb_pkg.sv
// Purpose: Types and the frame check function for both ends
// Assumes: Constants come from mb_params.svh
// Notes:   Check value is reflected, low byte goes out first
`include "mb_params.svh"

package mb_pkg;

  typedef enum logic [5:0]
  {
    st_rx  = 6'h01,
    st_chk = 6'h02,
    st_rdc = 6'h04,
    st_rdr = 6'h08,
    st_wr  = 6'h10,
    st_tx  = 6'h20
  } slv_state_e;

  typedef enum logic [2:0]
  {
    mst_idle = 3'h1,
    mst_send = 3'h2,
    mst_wait = 3'h4
  } mst_state_e;

  typedef struct packed {
    slv_state_e       st;
    logic [3:0]       cnt;
    logic             bad;
    logic [15:0]      crc;
    logic [7:0][7:0]  rxb;
    logic [10:0][7:0] txb;
    logic [3:0]       txlen;
    logic [3:0]       txi;
    logic             tph;
    logic [5:0]       idx;
    logic [5:0]       num;
    logic [31:0]      coils;
    logic             bcast;
    logic [15:0]      acc_addr;
    logic             acc_coil;
    logic             acc_wr;
    logic [15:0]      acc_wdata;
    logic [7:0]       r_data;
    logic             r_valid;
    logic             r_last;
  } slv_s;

  typedef struct packed {
    mst_state_e       st;
    logic [5:0][7:0]  txb;
    logic [3:0]       txi;
    logic             tph;
    logic [15:0]      crc;
    logic             bcast;
    logic [12:0][7:0] rxb;
    logic [3:0]       rcnt;
    logic [9:0]       tmo;
    logic [7:0]       q_data;
    logic             q_valid;
    logic             q_last;
    logic             rsp_valid;
    logic             rsp_ok;
    logic             rsp_tmo;
    logic [3:0]       rsp_len;
  } mst_s;

  // Frame check over one byte, polynomial x16+x15+x2+1
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++)
    begin
      r = r[0] ? ((r >> 1) ^ `MB_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// >>> src/mb_link_if.sv
// Purpose: Byte link between the control master and the slave
// Assumes: Both ends on one clock; no back-pressure on either direction
// Notes:   q_* carries queries, r_* carries responses; *_last marks frame end
`timescale 1ns/1ps

interface mb_link_if;
  logic [7:0] q_data;
  logic       q_valid;
  logic       q_last;
  logic [7:0] r_data;
  logic       r_valid;
  logic       r_last;

  modport slave_end
  (
    input  q_data,
    input  q_valid,
    input  q_last,
    output r_data,
    output r_valid,
    output r_last
  );

  modport master_end
  (
    output q_data,
    output q_valid,
    output q_last,
    input  r_data,
    input  r_valid,
    input  r_last
  );
endinterface

// >>> src/mb_slave.sv
// Purpose: Slave command handler for coil and holding register access
// Assumes: Queries arrive as whole frames; the master takes every response byte
// Notes:   Access port answers in the same cycle as the registered address
`timescale 1ns/1ps
`include "mb_params.svh"

module mb_slave
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  mb_link_if.slave_end     lnk,
  input  wire logic [7:0]  my_addr_in,
  output logic      [15:0] acc_addr_out,
  output logic             acc_coil_out,
  output logic             acc_wr_out,
  output logic      [15:0] acc_wdata_out,
  input  wire logic        acc_rd_coil_in,
  input  wire logic [15:0] acc_rd_reg_in,
  input  wire logic        acc_wr_rej_in
);

  mb_pkg::slv_s q;
  mb_pkg::slv_s d;

  logic [7:0]  f_adr;
  logic [7:0]  f_fn;
  logic [15:0] f_w0;
  logic [15:0] f_w1;
  logic [7:0]  exc;
  logic        ok;
  logic        bit_v;
  logic [3:0]  nbytes;
  logic [3:0]  ti;

  assign f_adr = q.rxb[0];
  assign f_fn  = q.rxb[1];
  assign f_w0  = {q.rxb[2], q.rxb[3]};
  assign f_w1  = {q.rxb[4], q.rxb[5]};

  assign acc_addr_out  = q.acc_addr;
  assign acc_coil_out  = q.acc_coil;
  assign acc_wr_out    = q.acc_wr;
  assign acc_wdata_out = q.acc_wdata;
  assign lnk.r_data    = q.r_data;
  assign lnk.r_valid   = q.r_valid;
  assign lnk.r_last    = q.r_last;

  always_comb
  begin
    d      = q;
    exc    = 8'h00;
    ok     = 1'b0;
    bit_v  = 1'b0;
    nbytes = 4'h0;
    ti     = 4'h0;
    d.r_valid = 1'b0;
    d.r_last  = 1'b0;
    d.acc_wr  = 1'b0;
    unique case (q.st)
      mb_pkg::st_rx:
      begin
        if (lnk.q_valid)
        begin
          if (q.cnt < `MB_REQ_LEN)
          begin
            d.rxb[q.cnt[2:0]] = lnk.q_data;
          end
          else
          begin
            d.bad = 1'b1;
          end
          if (q.cnt != `MB_CNT_SAT)
          begin
            d.cnt = q.cnt + 4'h1;
          end
          d.crc = mb_pkg::crc_step(q.crc, lnk.q_data);
          if (lnk.q_last)
          begin
            d.st = mb_pkg::st_chk;
          end
        end
      end
      mb_pkg::st_chk:
      begin
        d.st    = mb_pkg::st_rx;
        d.cnt   = 4'h0;
        d.bad   = 1'b0;
        d.crc   = `MB_CRC_INIT;
        d.idx   = 6'h00;
        d.coils = 32'h0000_0000;
        d.txi   = 4'h0;
        d.tph   = 1'b0;
        d.bcast = (f_adr == `MB_ADDR_BCAST);
        ok = (q.cnt == `MB_REQ_LEN) && !q.bad && (q.crc == 16'h0000)
          && (my_addr_in >= `MB_ADDR_MIN) && (my_addr_in <= `MB_ADDR_MAX)
          && ((f_adr == my_addr_in) || (f_adr == `MB_ADDR_BCAST));
        if (f_adr == `MB_ADDR_BCAST && f_fn != `MB_FN_WR_COIL && f_fn != `MB_FN_WR_REG)
        begin
          ok = 1'b0;
        end
        if (ok)
        begin
          d.txb[0]   = f_adr;
          d.txb[1]   = f_fn;
          d.acc_addr = f_w0;
          unique case (f_fn)
            `MB_FN_RD_COIL:
            begin
              if (f_w1 == 16'h0000 || f_w1 > {10'h000, `MB_COIL_MAX})
              begin
                exc = `MB_EXC_DATA;
              end
              else
              begin
                d.num      = f_w1[5:0];
                d.acc_coil = 1'b1;
                d.st       = mb_pkg::st_rdc;
              end
            end
            `MB_FN_RD_REG:
            begin
              if (f_w1 == 16'h0000 || f_w1 > {10'h000, `MB_REG_MAX})
              begin
                exc = `MB_EXC_DATA;
              end
              else if ({1'b0, f_w0} + {1'b0, f_w1} > {1'b0, `MB_REG_LIMIT})
              begin
                exc = `MB_EXC_ADDR;
              end
              else
              begin
                d.num      = f_w1[5:0];
                d.acc_coil = 1'b0;
                d.st       = mb_pkg::st_rdr;
              end
            end
            `MB_FN_WR_COIL:
            begin
              if (f_w1 != `MB_COIL_ON && f_w1 != `MB_COIL_OFF)
              begin
                exc = `MB_EXC_DATA;
              end
              else if (f_w0 >= `MB_COIL_LIMIT)
              begin
                exc = `MB_EXC_ADDR;
              end
              else
              begin
                d.acc_coil  = 1'b1;
                d.acc_wdata = {15'h0000, (f_w1 == `MB_COIL_ON)};
                d.acc_wr    = 1'b1;
                d.st        = mb_pkg::st_wr;
              end
            end
            `MB_FN_WR_REG:
            begin
              if (f_w0 >= `MB_REG_LIMIT)
              begin
                exc = `MB_EXC_ADDR;
              end
              else
              begin
                d.acc_coil  = 1'b0;
                d.acc_wdata = f_w1;
                d.acc_wr    = 1'b1;
                d.st        = mb_pkg::st_wr;
              end
            end
            default:
            begin
              exc = `MB_EXC_FUNC;
            end
          endcase
          if (exc != 8'h00)
          begin
            d.txb[1] = f_fn | `MB_FN_EXC_FLAG;
            d.txb[2] = exc;
            d.txlen  = 4'h3;
            d.st     = (f_adr == `MB_ADDR_BCAST) ? mb_pkg::st_rx : mb_pkg::st_tx;
          end
        end
      end
      mb_pkg::st_rdc:
      begin
        bit_v = (q.acc_addr < `MB_COIL_LIMIT) ? acc_rd_coil_in : 1'b0;
        d.coils[q.idx[4:0]] = bit_v;
        d.acc_addr = (q.acc_addr == 16'hffff) ? q.acc_addr : q.acc_addr + 16'h0001;
        d.idx      = q.idx + 6'h01;
        if (q.idx == q.num - 6'h01)
        begin
          nbytes   = 4'((q.num + 6'h07) >> 3);
          d.txb[2] = {4'h0, nbytes};
          for (int b = 0; b < 4; b++)
          begin
            d.txb[3 + b] = d.coils[8 * b +: 8];
          end
          d.txlen = 4'h3 + nbytes;
          d.st    = mb_pkg::st_tx;
        end
      end
      mb_pkg::st_rdr:
      begin
        ti = 4'h3 + 4'(q.idx << 1);
        d.txb[ti]        = acc_rd_reg_in[15:8];
        d.txb[ti + 4'h1] = acc_rd_reg_in[7:0];
        d.acc_addr = q.acc_addr + 16'h0001;
        d.idx      = q.idx + 6'h01;
        if (q.idx == q.num - 6'h01)
        begin
          d.txb[2] = {1'b0, q.num, 1'b0};
          d.txlen  = 4'h3 + 4'(q.num << 1);
          d.st     = mb_pkg::st_tx;
        end
      end
      mb_pkg::st_wr:
      begin
        if (acc_wr_rej_in)
        begin
          d.txb[1] = f_fn | `MB_FN_EXC_FLAG;
          d.txb[2] = `MB_EXC_REJECT;
          d.txlen  = 4'h3;
        end
        else
        begin
          for (int b = 2; b < 6; b++)
          begin
            d.txb[b] = q.rxb[b];
          end
          d.txlen = 4'h6;
        end
        d.st = q.bcast ? mb_pkg::st_rx : mb_pkg::st_tx;
      end
      mb_pkg::st_tx:
      begin
        d.r_valid = 1'b1;
        if (q.txi < q.txlen)
        begin
          d.r_data = q.txb[q.txi];
          d.crc    = mb_pkg::crc_step(q.crc, q.txb[q.txi]);
          d.txi    = q.txi + 4'h1;
        end
        else if (!q.tph)
        begin
          d.r_data = q.crc[7:0];
          d.tph    = 1'b1;
        end
        else
        begin
          d.r_data = q.crc[15:8];
          d.r_last = 1'b1;
          d.crc    = `MB_CRC_INIT;
          d.st     = mb_pkg::st_rx;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      q       <= '0;
      q.st    <= mb_pkg::st_rx;
      q.crc   <= `MB_CRC_INIT;
    end
    else
    begin
      q <= d;
    end
  end

endmodule

// >>> src/mb_master.sv
// Purpose: Control master end: sends one query, collects one response
// Assumes: One outstanding query at a time
// Notes:   Broadcast queries return to idle without waiting
`timescale 1ns/1ps
`include "mb_params.svh"

module mb_master
(
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  mb_link_if.master_end     lnk,
  input  wire logic         cmd_valid_in,
  output logic              cmd_ready_out,
  input  wire logic [7:0]   cmd_addr_in,
  input  wire logic [7:0]   cmd_func_in,
  input  wire logic [15:0]  cmd_w0_in,
  input  wire logic [15:0]  cmd_w1_in,
  output logic              rsp_valid_out,
  output logic              rsp_crc_ok_out,
  output logic              rsp_timeout_out,
  output logic      [3:0]   rsp_len_out,
  output logic      [103:0] rsp_data_out
);

  mb_pkg::mst_s q;
  mb_pkg::mst_s d;

  assign cmd_ready_out   = (q.st == mb_pkg::mst_idle);
  assign lnk.q_data      = q.q_data;
  assign lnk.q_valid     = q.q_valid;
  assign lnk.q_last      = q.q_last;
  assign rsp_valid_out   = q.rsp_valid;
  assign rsp_crc_ok_out  = q.rsp_ok;
  assign rsp_timeout_out = q.rsp_tmo;
  assign rsp_len_out     = q.rsp_len;
  assign rsp_data_out    = q.rxb;

  always_comb
  begin
    d = q;
    d.q_valid   = 1'b0;
    d.q_last    = 1'b0;
    d.rsp_valid = 1'b0;
    d.rsp_tmo   = 1'b0;
    unique case (q.st)
      mb_pkg::mst_idle:
      begin
        if (cmd_valid_in)
        begin
          d.txb   = {cmd_w1_in[7:0], cmd_w1_in[15:8], cmd_w0_in[7:0], cmd_w0_in[15:8],
                     cmd_func_in, cmd_addr_in};
          d.bcast = (cmd_addr_in == `MB_ADDR_BCAST);
          d.txi   = 4'h0;
          d.tph   = 1'b0;
          d.crc   = `MB_CRC_INIT;
          d.st    = mb_pkg::mst_send;
        end
      end
      mb_pkg::mst_send:
      begin
        d.q_valid = 1'b1;
        if (q.txi < 4'h6)
        begin
          d.q_data = q.txb[q.txi];
          d.crc    = mb_pkg::crc_step(q.crc, q.txb[q.txi]);
          d.txi    = q.txi + 4'h1;
        end
        else if (!q.tph)
        begin
          d.q_data = q.crc[7:0];
          d.tph    = 1'b1;
        end
        else
        begin
          d.q_data = q.crc[15:8];
          d.q_last = 1'b1;
          d.crc    = `MB_CRC_INIT;
          d.rcnt   = 4'h0;
          d.tmo    = 10'h000;
          d.rxb    = '0;
          d.st     = q.bcast ? mb_pkg::mst_idle : mb_pkg::mst_wait;
        end
      end
      mb_pkg::mst_wait:
      begin
        d.tmo = q.tmo + 10'h001;
        if (lnk.r_valid)
        begin
          if (q.rcnt < `MB_RSP_MAX)
          begin
            d.rxb[q.rcnt] = lnk.r_data;
            d.rcnt        = q.rcnt + 4'h1;
          end
          d.crc = mb_pkg::crc_step(q.crc, lnk.r_data);
          if (lnk.r_last)
          begin
            d.rsp_valid = 1'b1;
            d.rsp_ok    = (d.crc == 16'h0000);
            d.rsp_len   = d.rcnt;
            d.st        = mb_pkg::mst_idle;
          end
        end
        else if (q.tmo == `MB_RSP_TIMEOUT)
        begin
          d.rsp_tmo = 1'b1;
          d.st      = mb_pkg::mst_idle;
        end
      end
      default:
      begin
        d.st = mb_pkg::mst_idle;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      q     <= '0;
      q.st  <= mb_pkg::mst_idle;
      q.crc <= `MB_CRC_INIT;
    end
    else
    begin
      q <= d;
    end
  end

endmodule

// >>> sim/mb_link_chk.sv
// Purpose: Checker on the query and response byte streams
// Assumes: Both ends on clk_in; srst_in synchronous, active high
// Notes:   Sees only the link signals
`timescale 1ns/1ps

module mb_link_chk
(
  input wire logic       clk_in,
  input wire logic       srst_in,
  input wire logic [7:0] q_data_in,
  input wire logic       q_valid_in,
  input wire logic       q_last_in,
  input wire logic [7:0] r_data_in,
  input wire logic       r_valid_in,
  input wire logic       r_last_in
);
  logic [3:0]      qn;
  logic [3:0]      rn;
  logic [7:0][7:0] qb;
  logic [15:0]     rc;
  logic [15:0]     rc_n;
  logic            rx;
  logic            exc;
  logic [15:0]     cnt;

  function automatic logic [15:0] fcs(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++)
    begin
      r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    end
    return r;
  endfunction

  assign rc_n = fcs(rc, r_data_in);
  assign exc  = rx | (rn == 4'h1 && r_data_in[7]);
  assign cnt  = {qb[4], qb[5]};

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      qn <= 4'h0;
      rn <= 4'h0;
      rc <= 16'hffff;
      rx <= 1'b0;
    end
    else
    begin
      if (q_valid_in)
        qb[qn[2:0]] <= q_data_in;
      if (q_valid_in)
        qn <= q_last_in ? 4'h0 : qn + 4'h1;
      if (r_valid_in)
        rn <= r_last_in ? 4'h0 : rn + 4'h1;
      if (r_valid_in)
        rc <= r_last_in ? 16'hffff : rc_n;
      if (r_valid_in)
        rx <= r_last_in ? 1'b0 : exc;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  qry_len_a: assert property (q_last_in |-> q_valid_in && qn == 4'h7)
    else $error("query frame not eight bytes");
  rsp_addr_a: assert property (r_valid_in && rn == 4'h0 |->
    r_data_in == qb[0] && qb[0] != 8'h00)
    else $error("response address wrong or broadcast answered");
  rsp_func_a: assert property (r_valid_in && rn == 4'h1 |->
    r_data_in == qb[1] || r_data_in == (qb[1] | 8'h80))
    else $error("response function code wrong");
  exc_len_a: assert property (r_valid_in && rn == 4'h1 && r_data_in[7] |=>
    r_valid_in ##1 r_valid_in ##1 r_last_in)
    else $error("exception frame length wrong");
  rsp_run_a: assert property (r_valid_in && !r_last_in |=> r_valid_in)
    else $error("response bytes not contiguous");
  rsp_crc_a: assert property (r_last_in |-> r_valid_in && rc_n == 16'h0000)
    else $error("response check value wrong");
  coil_cnt_a: assert property (r_valid_in && rn == 4'h2 && !exc && qb[1] == 8'h01 |->
    {8'h00, r_data_in} == ((cnt + 16'h0007) >> 3))
    else $error("coil byte count wrong");
  reg_cnt_a: assert property (r_valid_in && rn == 4'h2 && !exc && qb[1] == 8'h03 |->
    {8'h00, r_data_in} == (cnt << 1))
    else $error("register byte count wrong");
  echo_a: assert property (r_valid_in && !exc && (qb[1] == 8'h05 || qb[1] == 8'h06) |->
    r_data_in == qb[rn[2:0]])
    else $error("write echo differs");
  coil_lim_a: assert property (r_valid_in && rn == 4'h1 && r_data_in == 8'h01 |->
    cnt inside {[16'h0001:16'h0020]})
    else $error("coil count out of range answered");

  cover property (r_valid_in && rn == 4'h1 && r_data_in == 8'h01);
  cover property (r_valid_in && rn == 4'h1 && r_data_in == 8'h03);
  cover property (r_valid_in && rn == 4'h1 && r_data_in[7]);
  cover property (r_last_in && qb[1] == 8'h06);
endmodule

// >>> sim/test_modbus_rtu_coil_register_slave.sv
// Purpose: Bench for the slave command handler driven through the master end
// Assumes: Coil and register store modelled here on the access port
// Notes:   Expected frames built from the store and the frame rules
`timescale 1ns/1ps

module test_modbus_rtu_coil_register_slave;
  logic         clk_in = 1'b0;
  logic         srst_in = 1'b1;
  logic [7:0]   my_addr = 8'h08;
  logic         cmd_valid = 1'b0;
  logic [7:0]   cmd_addr = 8'h00;
  logic [7:0]   cmd_func = 8'h00;
  logic [15:0]  cmd_w0 = 16'h0000;
  logic [15:0]  cmd_w1 = 16'h0000;
  logic         rej = 1'b0;
  logic [63:0]  cm = 64'h0000_0000_0000_0b80;
  logic [15:0]  rg [64];
  logic [15:0]  acc_addr;
  logic         acc_coil;
  logic         acc_wr;
  logic [15:0]  acc_wdata;
  logic         cmd_ready;
  logic         rsp_valid;
  logic         rsp_ok;
  logic         rsp_tmo;
  logic [3:0]   rsp_len;
  logic [103:0] rsp_data;
  int           n_errors = 0;
  int           comparisons = 0;

  mb_link_if lnk ();

  always #20 clk_in = ~clk_in;

  mb_slave i_mb_slave
  (
    .clk_in         (clk_in),
    .srst_in        (srst_in),
    .lnk            (lnk),
    .my_addr_in     (my_addr),
    .acc_addr_out   (acc_addr),
    .acc_coil_out   (acc_coil),
    .acc_wr_out     (acc_wr),
    .acc_wdata_out  (acc_wdata),
    .acc_rd_coil_in (cm[acc_addr[5:0]]),
    .acc_rd_reg_in  (rg[acc_addr[5:0]]),
    .acc_wr_rej_in  (rej)
  );

  mb_master i_mb_master
  (
    .clk_in          (clk_in),
    .srst_in         (srst_in),
    .lnk             (lnk),
    .cmd_valid_in    (cmd_valid),
    .cmd_ready_out   (cmd_ready),
    .cmd_addr_in     (cmd_addr),
    .cmd_func_in     (cmd_func),
    .cmd_w0_in       (cmd_w0),
    .cmd_w1_in       (cmd_w1),
    .rsp_valid_out   (rsp_valid),
    .rsp_crc_ok_out  (rsp_ok),
    .rsp_timeout_out (rsp_tmo),
    .rsp_len_out     (rsp_len),
    .rsp_data_out    (rsp_data)
  );

  mb_link_chk i_mb_link_chk
  (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .q_data_in  (lnk.q_data),
    .q_valid_in (lnk.q_valid),
    .q_last_in  (lnk.q_last),
    .r_data_in  (lnk.r_data),
    .r_valid_in (lnk.r_valid),
    .r_last_in  (lnk.r_last)
  );

  // Store side of the access port
  always @(posedge clk_in)
  begin
    if (acc_wr && !rej && acc_coil)
      cm[acc_addr[5:0]] <= acc_wdata[0];
    if (acc_wr && !rej && !acc_coil)
      rg[acc_addr[5:0]] <= acc_wdata;
  end

  function automatic logic [15:0] fcs(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++)
    begin
      r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    end
    return r;
  endfunction

  task automatic cmp(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic query(input logic [7:0] a, input logic [7:0] f, input logic [15:0] w0,
                       input logic [15:0] w1, input logic dr);
    logic [7:0]  ex[$];
    logic [7:0]  e;
    logic [31:0] d;
    logic [15:0] c;
    int          i;
    int          rv;
    int          lim;
    ex = {a, f};
    e = 8'h00;
    c = 16'hffff;
    case (f)
      8'h01:
        if (w1 == 16'h0000 || w1 > 16'h0020)
          e = 8'h03;
        else
        begin
          ex.push_back(8'((w1 + 16'h0007) >> 3));
          for (i = 0; i < 32; i++)
            d[i] = (i < w1) && (w0 + i < 64) && cm[6'(w0 + i)];
          for (i = 0; i < ex[2]; i++)
            ex.push_back(d[8 * i +: 8]);
        end
      8'h03:
        if (w1 == 16'h0000 || w1 > 16'h0004)
          e = 8'h03;
        else if (w0 + w1 > 64)
          e = 8'h02;
        else
        begin
          ex.push_back(8'(w1 * 2));
          for (i = 0; i < w1; i++)
          begin
            ex.push_back(rg[6'(w0 + i)][15:8]);
            ex.push_back(rg[6'(w0 + i)][7:0]);
          end
        end
      8'h05, 8'h06:
        if (f == 8'h05 && w1 != 16'hff00 && w1 != 16'h0000)
          e = 8'h03;
        else if (w0 >= 16'h0040)
          e = 8'h02;
        else if (rej)
          e = 8'h22;
        else
          ex = {ex, w0[15:8], w0[7:0], w1[15:8], w1[7:0]};
      default:
        e = 8'h01;
    endcase
    if (e != 8'h00)
      ex = {a, f | 8'h80, e};
    foreach (ex[k])
      c = fcs(c, ex[k]);
    ex = {ex, c[7:0], c[15:8]};
    @(negedge clk_in);
    cmp(cmd_ready === 1'b1, "master busy");
    cmd_addr = a;
    cmd_func = f;
    cmd_w0 = w0;
    cmd_w1 = w1;
    cmd_valid = 1'b1;
    @(negedge clk_in);
    cmd_valid = 1'b0;
    rv = 0;
    lim = (a == 8'h00) ? 40 : 1100;
    for (i = 0; i < lim && rsp_valid !== 1'b1 && rsp_tmo !== 1'b1; i++)
    begin
      @(negedge clk_in);
      if (lnk.r_valid === 1'b1)
        rv++;
    end
    if (a == 8'h00)
      cmp(rv == 0 && i == lim, "broadcast answered");
    else if (i == lim)
    begin
      cmp(1'b0, "wait ran out");
      conclude();
    end
    else if (dr)
      cmp(rsp_tmo === 1'b1 && rv == 0, "foreign frame answered");
    else
    begin
      cmp(rsp_valid === 1'b1 && rsp_ok === 1'b1, "no good response");
      cmp(rv == ex.size(), "response byte count");
      cmp(rsp_len === 4'(ex.size()), "length");
      foreach (ex[k])
        cmp(rsp_data[8 * k +: 8] === ex[k], "byte");
    end
  endtask

  initial
  begin
    for (int k = 0; k < 64; k++)
      rg[k] = {8'(k), 8'(k * 3 + 1)};
    repeat (6) @(negedge clk_in);
    srst_in = 1'b0;
    query(8'h08, 8'h01, 16'h0007, 16'h0006, 1'b0);
    query(8'h08, 8'h01, 16'h0000, 16'h0020, 1'b0);
    query(8'h08, 8'h01, 16'h003c, 16'h000a, 1'b0);
    query(8'h08, 8'h01, 16'hfff8, 16'h0010, 1'b0);
    query(8'h08, 8'h01, 16'h0000, 16'h0000, 1'b0);
    query(8'h08, 8'h01, 16'h0000, 16'h0021, 1'b0);
    query(8'h08, 8'h03, 16'h0019, 16'h0003, 1'b0);
    query(8'h08, 8'h03, 16'h0000, 16'h0004, 1'b0);
    query(8'h08, 8'h03, 16'h0000, 16'h0005, 1'b0);
    query(8'h08, 8'h03, 16'h003e, 16'h0004, 1'b0);
    query(8'h08, 8'h05, 16'h0001, 16'hff00, 1'b0);
    cmp(cm[1] === 1'b1, "coil not on");
    query(8'h08, 8'h05, 16'h0001, 16'h0000, 1'b0);
    cmp(cm[1] === 1'b0, "coil not off");
    query(8'h08, 8'h05, 16'h0001, 16'h1234, 1'b0);
    query(8'h08, 8'h05, 16'h0040, 16'hff00, 1'b0);
    query(8'h08, 8'h06, 16'h0041, 16'h0001, 1'b0);
    rej = 1'b1;
    query(8'h08, 8'h05, 16'h0001, 16'hff00, 1'b0);
    query(8'h08, 8'h06, 16'h003a, 16'h01f4, 1'b0);
    cmp(cm[1] === 1'b0 && rg[6'h3a] !== 16'h01f4, "refused write stored");
    rej = 1'b0;
    query(8'h08, 8'h06, 16'h003a, 16'h01f4, 1'b0);
    cmp(rg[6'h3a] === 16'h01f4, "register not stored");
    query(8'h08, 8'h03, 16'h003a, 16'h0001, 1'b0);
    query(8'h00, 8'h05, 16'h0002, 16'hff00, 1'b0);
    cmp(cm[2] === 1'b1, "broadcast write lost");
    query(8'h00, 8'h01, 16'h0000, 16'h0001, 1'b0);
    query(8'h08, 8'h02, 16'h0000, 16'h0001, 1'b0);
    query(8'h09, 8'h03, 16'h0000, 16'h0001, 1'b1);
    my_addr = 8'h21;
    query(8'h21, 8'h03, 16'h0000, 16'h0001, 1'b1);
    conclude();
  end
endmodule
